// ==== hdl/piv_group_arb.sv ====
// piv_group_arb: fixed-priority winner search for one source group.
// assumes request vector bit 0 is the highest rank; output registered.
`timescale 1ns/10ps
module piv_group_arb import piv_pkg::*; #(
  parameter int N = 4,
  parameter int BASE = 0
) (
  input wire logic clk_sys_in,
  input wire logic rst_n_in,
  input wire logic ce_in,
  input wire logic [N-1:0] req_in,
  output logic any_out,
  output logic [15:0] offset_out
);
  // ==========================================================
  // priority pick, lowest index wins
  logic [15:0] pick_next;
  always_comb begin
    pick_next = PHANTOM_OFFSET; // phantom when nobody asks
    for (int i = N - 1; i >= 0; i--) begin
      if (req_in[i]) begin
        pick_next = SRC_OFFSET[BASE + i];
      end
    end
  end
  // registered so the read mux sees a stable word
  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      any_out <= 1'b0;
      offset_out <= PHANTOM_OFFSET;
    end else if (ce_in) begin
      any_out <= |req_in;
      offset_out <= pick_next;
    end
  end
endmodule : piv_group_arb

// ==== hdl/piv_pkg.sv ====
// piv_pkg: shared constants and carrier types for the peripheral
// interrupt vectoring block.
// assumes a single 50 MHz system clock and a 32-bit avalon-mm register bus.
package piv_pkg;
  // ==========================================================
  // register map (printed offsets are word indices; byte = 4 * index)
  localparam logic [15:0] IDX_SYS_VEC = 16'h701e; // system group offset
  localparam logic [15:0] IDX_EVA_VEC = 16'h7432; // event group a offset
  localparam logic [15:0] IDX_EVB_VEC = 16'h7433; // event group b offset
  localparam logic [15:0] IDX_EVC_VEC = 16'h7434; // event group c offset
  localparam logic [15:0] IDX_SRC_FLAG = 16'h7500; // source flags, w1c
  localparam logic [15:0] IDX_SRC_EN = 16'h7501; // source enables
  localparam logic [15:0] IDX_LINE_MASK = 16'h7502; // line_mask_register
  localparam logic [15:0] IDX_LINE_PEND = 16'h7503; // line_pending_register, RO
  localparam logic [15:0] IDX_CORE_ST0 = 16'h7504; // core_status_zero
  localparam logic [15:0] IDX_IRQ_STAT = 16'h7505; // event status, w1c
  localparam logic [15:0] IDX_IRQ_MASK = 16'h7506; // event mask
  // ==========================================================
  // fields and reset values
  localparam int GIE_BIT = 9; // global_irq_disable position in status zero
  localparam logic [15:0] ST0_RESET = 16'h0200; // disable set at reset
  localparam logic [3:0] LINE_MASK_RESET = 4'h0;
  localparam logic [26:0] SRC_EN_RESET = 27'h0;
  localparam logic [15:0] PHANTOM_OFFSET = 16'h0000;
  localparam logic [15:0] RESET_VECTOR = 16'h0000;
  localparam logic [31:0] UNMAPPED_DATA = 32'h0000_0000;
  // ==========================================================
  // source numbering: 0..6 system, 7..13 group a, 14..25 group b,
  // 26..29 group c (30 sources, ranked by index inside a group)
  localparam int NUM_SRC = 30;
  localparam int SYS_LO = 0;
  localparam int SYS_N = 7;
  localparam int EVA_LO = 7;
  localparam int EVA_N = 7;
  localparam int EVB_LO = 14;
  localparam int EVB_N = 12;
  localparam int EVC_LO = 26;
  localparam int EVC_N = 4;
  // vector offsets per source, in priority order
  localparam logic [15:0] SRC_OFFSET [NUM_SRC] = '{
    16'h0001, 16'h0011, 16'h001f, 16'h0005, 16'h0006, 16'h0007, 16'h0010,
    16'h0020, 16'h0021, 16'h0022, 16'h0023, 16'h0024, 16'h0025, 16'h0026,
    16'h0027, 16'h0028, 16'h0029, 16'h002a, 16'h002b, 16'h002c,
    16'h002d, 16'h002e, 16'h002f, 16'h0030, 16'h0031, 16'h0032,
    16'h0033, 16'h0034, 16'h0035, 16'h0036};
  // core vector locations per line
  localparam logic [15:0] LINE_VECTOR [4] = '{16'h0002, 16'h0004, 16'h0006, 16'h0008};
  // ==========================================================
  // carriers
  typedef struct packed {
    logic [15:0] address; // word index
    logic read;
    logic write;
    logic [31:0] writedata;
  } piv_bus_req_type;
  typedef enum {ST_RUN, ST_JAM, ST_LOAD} piv_core_state_type;
endpackage : piv_pkg

// ==== hdl/piv_top.sv ====
// piv_top: two-level peripheral interrupt expansion and vectoring.
// assumes the core asks for a vector with ack_in and fetches through
// the jam/vector outputs; sources arrive as one-cycle request pulses.
// Function
// - per-line mask bit gates acknowledge
// - acknowledge forces vector-jam instruction onto bus
// - jam loads pc with line vector
// - no request gives phantom offset zero
// - reset highest, vector zero, never masked
// - external pins offsets 0001h 0011h 001fh line one
// - system group: spi 0005h, rx 0006h
// - tx 0007h then watchdog 0010h
// - group a line two, 0020h..0026h
// - group a rank protect, full, simple
// - simple compares 0024h..0026h
// - group b timers 0027h..0032h, line three
// - group c captures 0033h..0036h, line four
// - only enabled flagged sources reach arbitration
// - global disable bit nine, set on ack
// - group winner sets line pending flag
//
// Register access over Avalon-MM was chosen for this implementation.
`timescale 1ns/10ps
module piv_top import piv_pkg::*; #(
  parameter logic [15:0] JAM_OPCODE = 16'hbe40 // arbitrary encoding
) (
  input wire logic clk_sys_in,
  input wire logic rst_n_in, // also the system reset pin
  input wire logic ce_in,
  input wire logic [NUM_SRC-1:0] src_req_in, // peripheral request pulses
  input wire logic ack_in, // core ready to take an interrupt
  input wire logic [15:0] avs_address_in, // word index
  input wire logic avs_read_in,
  input wire logic avs_write_in,
  input wire logic [31:0] avs_writedata_in,
  output logic [31:0] avs_readdata_out,
  output logic avs_waitrequest_out,
  output logic [15:0] instr_bus_out, // forced opcode
  output logic instr_jam_out, // opcode valid
  output logic [15:0] pc_load_out, // vector location
  output logic pc_load_valid_out,
  output logic [3:0] line_ack_out, // acknowledged line, one-hot pulse
  output logic irq_out
);
  // ==========================================================
  // state
  logic [NUM_SRC-1:0] flag_reg; // per-source flags
  logic [NUM_SRC-1:0] en_reg; // per-source enables
  logic [3:0] mask_reg; // line_mask_register
  logic [3:0] pend_reg; // line_pending_register
  logic gie_reg; // global_irq_disable
  logic [3:0] stat_reg; // acknowledge events, w1c
  logic [3:0] imask_reg;
  logic [1:0] line_reg; // acknowledged line
  piv_core_state_type state_reg;
  piv_bus_req_type req;
  logic [NUM_SRC-1:0] fwd; // forwarded requests
  logic [3:0] grp_any;
  logic [15:0] grp_off [4];
  logic [3:0] take; // line that may be acknowledged now
  logic wr;
  logic rd;
  assign req = '{address: avs_address_in, read: avs_read_in,
                 write: avs_write_in, writedata: avs_writedata_in};
  assign wr = req.write && !avs_waitrequest_out && ce_in;
  assign rd = req.read && !avs_waitrequest_out && ce_in;
  assign fwd = flag_reg & en_reg;
  // ==========================================================
  // per-group arbiters, one generate loop
  localparam int G_LO [4] = '{SYS_LO, EVA_LO, EVB_LO, EVC_LO};
  localparam int G_N [4] = '{SYS_N, EVA_N, EVB_N, EVC_N};
  for (genvar g = 0; g < 4; g++) begin : g_grp
    piv_group_arb #(.N(G_N[g]), .BASE(G_LO[g])) u_arb (
      .clk_sys_in(clk_sys_in),
      .rst_n_in(rst_n_in),
      .ce_in(ce_in),
      .req_in(fwd[G_LO[g] +: G_N[g]]),
      .any_out(grp_any[g]),
      .offset_out(grp_off[g])
    );
  end
  // ==========================================================
  // source flags: set wins over software clear
  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      flag_reg <= '0;
    end else if (ce_in) begin
      if (wr && req.address == IDX_SRC_FLAG) begin
        flag_reg <= (flag_reg & ~req.writedata[NUM_SRC-1:0]) | src_req_in;
      end else begin
        flag_reg <= flag_reg | src_req_in;
      end
    end
  end
  // ==========================================================
  // line pending: winning group raises its line
  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      pend_reg <= 4'h0;
    end else if (ce_in) begin
      pend_reg <= grp_any;
    end
  end
  // highest pending unmasked line, only while global enable is open
  always_comb begin
    take = 4'h0;
    if (!gie_reg) begin
      for (int i = 3; i >= 0; i--) begin
        if (pend_reg[i] && mask_reg[i]) begin
          take = 4'h0;
          take[i] = 1'b1;
        end
      end
    end
  end
  // ==========================================================
  // core sequence: jam instruction, then load vector location
  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      state_reg <= ST_RUN;
      line_reg <= 2'd0;
      instr_bus_out <= 16'h0000;
      instr_jam_out <= 1'b0;
      pc_load_out <= RESET_VECTOR;
      pc_load_valid_out <= 1'b1; // reset vector, unmaskable
      line_ack_out <= 4'h0;
    end else if (ce_in) begin
      instr_jam_out <= 1'b0;
      pc_load_valid_out <= 1'b0;
      line_ack_out <= 4'h0;
      case (state_reg)
        ST_RUN: begin
          if (ack_in && |take) begin
            for (int i = 0; i < 4; i++) begin
              if (take[i]) begin
                line_reg <= 2'(i);
              end
            end
            line_ack_out <= take;
            instr_bus_out <= JAM_OPCODE;
            instr_jam_out <= 1'b1;
            state_reg <= ST_JAM;
          end
        end
        ST_JAM: begin
          pc_load_out <= LINE_VECTOR[line_reg];
          pc_load_valid_out <= 1'b1;
          state_reg <= ST_LOAD;
        end
        ST_LOAD: begin
          state_reg <= ST_RUN;
        end
        default: begin
          state_reg <= ST_RUN;
        end
      endcase
    end
  end
  // ==========================================================
  // global disable: set at reset and on acknowledge
  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      gie_reg <= ST0_RESET[GIE_BIT];
    end else if (ce_in) begin
      if (state_reg == ST_RUN && ack_in && |take) begin
        gie_reg <= 1'b1;
      end else if (wr && req.address == IDX_CORE_ST0) begin
        gie_reg <= req.writedata[GIE_BIT];
      end
    end
  end
  // ==========================================================
  // software control registers
  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      en_reg <= SRC_EN_RESET[NUM_SRC-1:0];
      mask_reg <= LINE_MASK_RESET;
      imask_reg <= 4'h0;
    end else if (wr) begin
      case (req.address)
        IDX_SRC_EN: en_reg <= req.writedata[NUM_SRC-1:0];
        IDX_LINE_MASK: mask_reg <= req.writedata[3:0];
        IDX_IRQ_MASK: imask_reg <= req.writedata[3:0];
        default: begin
        end
      endcase
    end
  end
  // acknowledge events: sticky, set wins over w1c
  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      stat_reg <= 4'h0;
    end else if (ce_in) begin
      if (wr && req.address == IDX_IRQ_STAT) begin
        stat_reg <= (stat_reg & ~req.writedata[3:0]) | line_ack_out;
      end else begin
        stat_reg <= stat_reg | line_ack_out;
      end
    end
  end
  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      irq_out <= 1'b0;
    end else if (ce_in) begin
      irq_out <= |(stat_reg & imask_reg);
    end
  end
  // ==========================================================
  // avalon slave: one wait cycle, then data and release
  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      avs_waitrequest_out <= 1'b1;
    end else if (ce_in) begin
      avs_waitrequest_out <= !((req.read || req.write) && avs_waitrequest_out);
    end
  end
  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      avs_readdata_out <= UNMAPPED_DATA;
    end else if (ce_in && req.read && avs_waitrequest_out) begin
      case (req.address)
        IDX_SYS_VEC: avs_readdata_out <= {16'h0000, grp_off[0]};
        IDX_EVA_VEC: avs_readdata_out <= {16'h0000, grp_off[1]};
        IDX_EVB_VEC: avs_readdata_out <= {16'h0000, grp_off[2]};
        IDX_EVC_VEC: avs_readdata_out <= {16'h0000, grp_off[3]};
        IDX_SRC_FLAG: avs_readdata_out <= {2'b00, flag_reg};
        IDX_SRC_EN: avs_readdata_out <= {2'b00, en_reg};
        IDX_LINE_MASK: avs_readdata_out <= {28'h0, mask_reg};
        IDX_LINE_PEND: avs_readdata_out <= {28'h0, pend_reg};
        IDX_CORE_ST0: avs_readdata_out <= {22'h0, gie_reg, 9'h0};
        IDX_IRQ_STAT: avs_readdata_out <= {28'h0, stat_reg};
        IDX_IRQ_MASK: avs_readdata_out <= {28'h0, imask_reg};
        default: avs_readdata_out <= UNMAPPED_DATA;
      endcase
    end
  end
  // ==========================================================
  // checks
  a_ack_needs_mask: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
    $rose(instr_jam_out) |-> (line_ack_out & ~$past(mask_reg)) == 4'h0)
    else $error("acknowledged a masked line");
  a_jam_opcode: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
    instr_jam_out |-> instr_bus_out == JAM_OPCODE)
    else $error("jam opcode wrong");
  a_jam_then_load: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
    (instr_jam_out && ce_in) |=> pc_load_valid_out)
    else $error("vector load missing after jam");
  a_gie_on_ack: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
    (instr_jam_out && ce_in) |-> gie_reg)
    else $error("global disable not set on acknowledge");
  a_no_ack_disabled: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
    ($past(gie_reg) && $past(state_reg) == ST_RUN) |-> !$rose(instr_jam_out))
    else $error("acknowledge while globally disabled");
  a_phantom_sys: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
    (ce_in && !grp_any[0]) |-> grp_off[0] == PHANTOM_OFFSET)
    else $error("phantom offset wrong");
  a_pend_follows: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
    ce_in |=> pend_reg == $past(grp_any))
    else $error("pending flag did not follow group");
  a_spi_first: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
    (ce_in && fwd[3:0] == 4'h8) |=> grp_off[0] == 16'h0005)
    else $error("serial peripheral offset wrong");
  a_line_vector: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
    (pc_load_valid_out && $past(state_reg) == ST_JAM) |->
      pc_load_out == {12'h000, 1'b0, $past(line_reg), 1'b0} + 16'h0002)
    else $error("vector location wrong");
  c_ack_seen: cover property (@(posedge clk_sys_in) instr_jam_out);
  c_read_vec: cover property (@(posedge clk_sys_in) rd && req.address == IDX_EVB_VEC);
  c_irq: cover property (@(posedge clk_sys_in) irq_out);
endmodule : piv_top

// ==== verification/piv_core_model.sv ====
// piv_core_model: core side that offers acknowledge and records the jam.
// assumes piv_top outputs are registered, one clock, async low reset.
`timescale 1ns/10ps
module piv_core_model (
  input wire logic clk_sys_in,
  input wire logic rst_n_in,
  input wire logic take_in, // core willing to take an interrupt
  input wire logic [3:0] delay_in, // cycles before the offer shows
  input wire logic [15:0] instr_in,
  input wire logic jam_in,
  input wire logic [15:0] pc_in,
  input wire logic pc_valid_in,
  input wire logic [3:0] line_in,
  output logic ack_out,
  output logic [15:0] opcode_out,
  output logic [15:0] vector_out,
  output logic [3:0] line_out,
  output logic [7:0] loads_out
);
  // ==========================================================
  // acknowledge offer, prompt or slow
  logic [3:0] wait_reg; // cycles the offer was held back
  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      wait_reg <= 4'h0;
    end else if (!take_in) begin // offer withdrawn, restart the count
      wait_reg <= 4'h0;
    end else if (wait_reg != delay_in) begin
      wait_reg <= wait_reg + 4'h1;
    end
  end
  // a plain level; gating by mask and disable is left to the device
  assign ack_out = take_in && (wait_reg == delay_in);
  // ==========================================================
  // capture of the forced opcode and the pc load
  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      opcode_out <= 16'h0000;
      line_out <= 4'h0;
      vector_out <= 16'hffff; // no legal vector, so a reset load shows
      loads_out <= 8'h00;
    end else begin
      if (jam_in) begin
        opcode_out <= instr_in;
        line_out <= line_in;
      end
      if (pc_valid_in) begin
        vector_out <= pc_in;
        loads_out <= loads_out + 8'h01;
      end
    end
  end
endmodule : piv_core_model

// ==== verification/tb_peripheral_interrupt_vectoring.sv ====
// tb_peripheral_interrupt_vectoring: self-checking bench for piv_top.
// assumes piv_core_model stands in for the core on the ack side.
`timescale 1ns/10ps
module tb_peripheral_interrupt_vectoring import piv_pkg::*;;
  // ==========================================================
  // stimulus and observation
  localparam logic [15:0] JAM = 16'h1234; // arbitrary opcode
  logic clk_sys_in = 1'b0;
  logic rst_n_in = 1'b0;
  logic [NUM_SRC-1:0] src = '0; // request pulses
  logic [15:0] addr = 16'h0;
  logic rd = 1'b0;
  logic wr = 1'b0;
  logic [31:0] wdata = 32'h0;
  logic take_en = 1'b0;
  logic ce = 1'b1; // clock enable, dropped only by the freeze scenario
  logic [3:0] delay = 4'h0;
  logic [31:0] rdata;
  logic wait_req, jam, pcv, irq, ack;
  logic [15:0] instr, pc, opc, vec;
  logic [3:0] lack, line;
  logic [7:0] loads;
  int miscompares = 0;
  int n_tests = 0;
  always #10 clk_sys_in = ~clk_sys_in;
  // clock enable driven so that the freeze behaviour is exercised
  piv_top #(.JAM_OPCODE(JAM)) dut_u (.clk_sys_in(clk_sys_in), .rst_n_in(rst_n_in),
    .ce_in(ce), .src_req_in(src), .ack_in(ack), .avs_address_in(addr),
    .avs_read_in(rd), .avs_write_in(wr), .avs_writedata_in(wdata),
    .avs_readdata_out(rdata), .avs_waitrequest_out(wait_req), .instr_bus_out(instr),
    .instr_jam_out(jam), .pc_load_out(pc), .pc_load_valid_out(pcv),
    .line_ack_out(lack), .irq_out(irq));
  piv_core_model core_u (.clk_sys_in(clk_sys_in), .rst_n_in(rst_n_in), .take_in(take_en),
    .delay_in(delay), .instr_in(instr), .jam_in(jam), .pc_in(pc), .pc_valid_in(pcv),
    .line_in(lack), .ack_out(ack), .opcode_out(opc), .vector_out(vec),
    .line_out(line), .loads_out(loads));
  // ==========================================================
  // helpers
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    n_tests++;
    if (got !== exp) begin
      miscompares++;
      $display("Error at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask : chk
  // one avalon transfer; held until waitrequest is seen low
  task automatic bus(input logic w, input logic [15:0] a, input logic [31:0] d,
                     output logic [31:0] q);
    int n;
    n = 0;
    @(posedge clk_sys_in);
    addr <= a;
    rd <= !w;
    wr <= w;
    wdata <= d;
    do begin
      @(posedge clk_sys_in);
      n++;
    end while (wait_req !== 1'b0 && n < 50);
    q = rdata;
    rd <= 1'b0;
    wr <= 1'b0;
    if (n >= 50) chk(32'h1, 32'h0, "bus answer");
  endtask : bus
  task automatic wrt(input logic [15:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
    repeat (3) @(posedge clk_sys_in); // let flags and winners settle
  endtask : wrt
  task automatic rdc(input logic [15:0] a, input logic [31:0] exp, input string what);
    logic [31:0] q;
    bus(1'b0, a, 32'h0, q);
    chk(q, exp, what);
  endtask : rdc
  task automatic pulse(input logic [NUM_SRC-1:0] m);
    @(posedge clk_sys_in);
    src <= m;
    @(posedge clk_sys_in);
    src <= '0;
    repeat (4) @(posedge clk_sys_in);
  endtask : pulse
  // offer an acknowledge and see whether a vector load follows
  task automatic take(input logic [3:0] dly, input logic exp);
    int n;
    logic [7:0] l0;
    n = 0;
    l0 = loads;
    @(posedge clk_sys_in);
    take_en <= 1'b1;
    delay <= dly;
    while (loads === l0 && n < 30) begin
      @(posedge clk_sys_in);
      n++;
    end
    take_en <= 1'b0;
    chk({31'h0, loads !== l0}, {31'h0, exp}, "ack taken");
  endtask : take
  function automatic logic [15:0] gaddr(input int i);
    if (i < EVA_LO) return IDX_SYS_VEC;
    if (i < EVB_LO) return IDX_EVA_VEC;
    if (i < EVC_LO) return IDX_EVB_VEC;
    return IDX_EVC_VEC;
  endfunction : gaddr
  function automatic logic [15:0] eoff(input int i);
    logic [15:0] sys [7];
    sys = '{16'h0001, 16'h0011, 16'h001f, 16'h0005, 16'h0006, 16'h0007, 16'h0010};
    if (i < 7) return sys[i];
    return 16'h0020 + 16'(i - 7); // event groups run on consecutively
  endfunction : eoff
  // ==========================================================
  // scenarios
  task automatic t_regs;
    chk({16'h0, vec}, 32'h0, "reset vector");
    rdc(IDX_CORE_ST0, {16'h0, ST0_RESET}, "status zero");
    rdc(IDX_LINE_MASK, 32'h0, "line mask");
    wrt(16'h7fff, 32'hffffffff);
    rdc(16'h7fff, 32'h0, "unmapped");
    rdc(IDX_SYS_VEC, 32'h0, "phantom");
    $display("done: reset values");
  endtask : t_regs
  // all sources at once, then peel winners off one by one
  task automatic t_rank;
    wrt(IDX_SRC_EN, 32'h3fffffff);
    pulse('1);
    rdc(IDX_LINE_PEND, 32'hf, "pending lines");
    for (int i = 0; i < NUM_SRC; i++) begin
      rdc(gaddr(i), {16'h0, eoff(i)}, "ranked offset");
      wrt(IDX_SRC_FLAG, 32'h1 << i);
      if (i == NUM_SRC - 1 || gaddr(i) != gaddr(i + 1)) begin
        rdc(gaddr(i), 32'h0, "group empty");
      end
    end
    rdc(IDX_LINE_PEND, 32'h0, "none pending");
    $display("done: ranking and offsets");
  endtask : t_rank
  task automatic t_enable;
    wrt(IDX_SRC_EN, 32'h3ffffff7);
    pulse(30'h8);
    rdc(IDX_SYS_VEC, 32'h0, "disabled source");
    pulse(30'h10);
    rdc(IDX_SYS_VEC, 32'h6, "enabled source");
    wrt(IDX_SRC_EN, 32'h3fffffff);
    rdc(IDX_SYS_VEC, 32'h5, "flag kept");
    wrt(IDX_SRC_FLAG, 32'h3fffffff);
    $display("done: source enables");
  endtask : t_enable
  task automatic t_ack;
    int base [4] = '{SYS_LO, EVA_LO, EVB_LO, EVC_LO};
    for (int k = 0; k < 4; k++) begin
      wrt(IDX_SRC_FLAG, 32'h3fffffff);
      pulse(30'h1 << base[k]);
      wrt(IDX_LINE_MASK, 32'h1 << k);
      wrt(IDX_CORE_ST0, 32'h0);
      take(4'(k), 1'b1);
      chk({16'h0, opc}, {16'h0, JAM}, "jam opcode");
      chk({28'h0, line}, 32'h1 << k, "line acked");
      chk({16'h0, vec}, 32'h2 + 2 * k, "line vector");
      rdc(IDX_CORE_ST0, 32'h200, "disable on ack");
      take(4'h0, 1'b0);
    end
    rdc(IDX_IRQ_STAT, 32'hf, "ack events");
    wrt(IDX_IRQ_MASK, 32'h0);
    chk({31'h0, irq}, 32'h0, "irq masked");
    wrt(IDX_IRQ_MASK, 32'h2);
    chk({31'h0, irq}, 32'h1, "irq raised");
    wrt(IDX_IRQ_STAT, 32'h2);
    chk({31'h0, irq}, 32'h0, "irq cleared");
    $display("done: acknowledge per line");
  endtask : t_ack
  // line one masked off, then nothing unmasked, then both open
  task automatic t_mask;
    wrt(IDX_SRC_FLAG, 32'h3fffffff);
    pulse(30'h81);
    wrt(IDX_LINE_MASK, 32'h2);
    wrt(IDX_CORE_ST0, 32'h0);
    take(4'h2, 1'b1);
    chk({28'h0, line}, 32'h2, "masked line skipped");
    wrt(IDX_LINE_MASK, 32'h0);
    wrt(IDX_CORE_ST0, 32'h0);
    take(4'h0, 1'b0);
    wrt(IDX_LINE_MASK, 32'h3);
    take(4'h0, 1'b1);
    chk({28'h0, line}, 32'h1, "line one first");
    $display("done: line masks");
  endtask : t_mask
  // a request pulse while the enable is low must leave no flag behind
  task automatic t_freeze;
    wrt(IDX_SRC_FLAG, 32'h3fffffff);
    @(posedge clk_sys_in);
    ce <= 1'b0;
    pulse(30'h10);
    @(posedge clk_sys_in);
    ce <= 1'b1;
    repeat (3) @(posedge clk_sys_in);
    rdc(IDX_SYS_VEC, 32'h0, "frozen flag");
    $display("done: clock enable freeze");
  endtask : t_freeze
  // ==========================================================
  // run control
  task automatic end_sim;
    $display("comparisons %0d miscompares %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : end_sim
  initial begin
    repeat (3) @(posedge clk_sys_in);
    chk({31'h0, pcv}, 32'h1, "reset load");
    rst_n_in <= 1'b1;
    repeat (2) @(posedge clk_sys_in);
    t_regs();
    t_rank();
    t_enable();
    t_ack();
    t_mask();
    t_freeze();
    end_sim();
  end
  // watchdog: the whole run needs under a thousand cycles
  initial begin
    #400000;
    miscompares++;
    end_sim();
  end
endmodule : tb_peripheral_interrupt_vectoring
